// [hw/seph_pkg.sv]
`default_nettype none
package seph_pkg;
    // Status register layout
    localparam int ST_LOCK  = 7;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_LATCH = 1;
    localparam int ST_BUSY  = 0;
    // Instruction codes
    localparam logic [7:0] CMD_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
    localparam logic [7:0] CMD_STAT_RD   = 8'h05;
    localparam logic [7:0] CMD_STAT_WR   = 8'h01;
    localparam logic [7:0] CMD_ARR_WR    = 8'h02;
    // Serial counts
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] ADDR_LAST = 4'hF;
    localparam int         ARR_MSB   = 14;
    // Wishbone byte offsets
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_CTRL   = 4'h4;
    localparam logic [3:0] ADR_ARRWR  = 4'h8;
    localparam logic       CTRL_RST   = 1'b1;
    // Internal write cycle time
    localparam int CLK_MHZ    = 25;
    localparam int WR_TIME_US = 5;
    localparam int BUSY_CYC   = WR_TIME_US * CLK_MHZ;
    // Synchroniser lanes
    localparam int PIN_N    = 5;
    localparam int PIN_SCLK = 0;
    localparam int PIN_UEN  = 1;
    localparam int PIN_SDI  = 2;
    localparam int PIN_HOLD = 3;
    localparam int PIN_WP   = 4;
    typedef enum logic [2:0] {
        PH_CMD, PH_STAT_DATA, PH_ADDR, PH_DATA, PH_STAT_OUT, PH_IDLE
    } seph_phase_e;
    // Region guarded by the block-protect field
    function automatic logic in_prot(input logic [1:0] f,
                                     input logic [15:0] a);
        case (f)
            2'h1:    in_prot = &a[ARR_MSB -: 2];
            2'h2:    in_prot = a[ARR_MSB];
            2'h3:    in_prot = 1'b1;
            default: in_prot = 1'b0;
        endcase
    endfunction
endpackage
`default_nettype wire

// [hw/seph_core.sv]
// Function
// - Input bits are taken on the serial clock rising edge.
// - Output bits change after the serial clock falling edge.
// - Deselected: output off, standby unless a write cycle runs.
// - Nothing starts until a first falling unit enable after power-up.
// - Protect pin guards status bits except busy and latch flags.
// - Lock bit 0: status write accepted whenever latch is set.
// - Lock bit 1, protect pin high: status write accepted with latch.
// - Lock bit 1, protect pin low: status writes ignored, hard lock.
// - Hard lock also rejects writes into the protected array region.
// - Hard lock entered by lock bit and low pin, either order.
// - Hard lock left only by driving the protect pin high.
// - Soft protect blocks array writes in the block-protect region.
// - Array bytes outside the region accept writes with latch set.
// - Pause input honoured only while selected.
// - Pause entered when pause input low while serial clock low.
// - Paused: output off, inputs ignored, partial sequence kept.
// - Deselect while paused resets protocol; stays paused while low.
// - Status: lock b7, protect b3..b2, latch b1, busy b0.
// - Latch set by code 06h, cleared by code 04h.
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module seph_core #(
    parameter logic [7:0] NV_INIT = 8'h00
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial pins
    input  wire logic        sclk,
    input  wire logic        unit_en_n,
    input  wire logic        sdi,
    input  wire logic        pause_n,
    input  wire logic        protect_n,
    output logic             sdo,
    output logic             sdo_oe
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers, reset to idle pin levels so no false edge follows
    logic [seph_pkg::PIN_N-1:0] pins, syn1, syn2, prv;
    assign pins = {protect_n, pause_n, sdi, unit_en_n, sclk};
    for (genvar gi = 0; gi < seph_pkg::PIN_N; gi++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (srst) begin
                syn1[gi] <= (gi != seph_pkg::PIN_SCLK);
                syn2[gi] <= (gi != seph_pkg::PIN_SCLK);
                prv[gi]  <= (gi != seph_pkg::PIN_SCLK);
            end else begin
                syn1[gi] <= pins[gi];
                syn2[gi] <= syn1[gi];
                prv[gi]  <= syn2[gi];
            end
        end
    end
    logic sclk_s, sclk_rise, sclk_fall, selected, sel_fall, sel_rise;
    logic hold_low, din;
    assign sclk_s    = syn2[seph_pkg::PIN_SCLK];
    assign sclk_rise = sclk_s & ~prv[seph_pkg::PIN_SCLK];
    assign sclk_fall = ~sclk_s & prv[seph_pkg::PIN_SCLK];
    assign selected  = ~syn2[seph_pkg::PIN_UEN];
    assign sel_fall  = selected & prv[seph_pkg::PIN_UEN];
    assign sel_rise  = ~selected & ~prv[seph_pkg::PIN_UEN];
    assign hold_low  = ~syn2[seph_pkg::PIN_HOLD];
    assign din       = syn2[seph_pkg::PIN_SDI];
    ////////////////////////////////////////////////////////////////////
    // Protocol and protection state
    seph_pkg::seph_phase_e phase_reg, phase_next;
    logic [15:0] sh_reg, sh_next, addr_reg, addr_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [7:0]  out_reg, out_next, stat_d_reg, stat_d_next;
    logic [2:0]  ocnt_reg, ocnt_next;
    logic        lock_reg, lock_next, latch_reg, latch_next;
    logic [1:0]  bpf_reg, bpf_next;
    logic        armed_reg, armed_next, paused_reg, paused_next;
    logic        spend_reg, spend_next, wpend_reg, wpend_next;
    logic        sdo_reg, sdo_next, oe_reg, oe_next;
    logic [7:0]  busy_cnt_reg, busy_cnt_next;
    logic [25:0] arr_reg, arr_next;
    logic        busy, hard_lock_state, active, byte_end, data_ok, en_reg;
    logic [7:0]  status_reg, rx_byte;
    // Hard lock is pure logic of bit and pin, so either order enters it
    assign hard_lock_state = lock_reg & ~syn2[seph_pkg::PIN_WP];
    assign busy = |busy_cnt_reg;
    assign status_reg = {lock_reg, 3'h0, bpf_reg, latch_reg, busy};
    assign active = armed_reg & selected & ~paused_reg & en_reg;
    assign rx_byte = {sh_reg[6:0], din}; // Byte as it stands after this rise
    assign byte_end = cnt_reg == seph_pkg::BYTE_LAST;
    // Region check applies in both soft and hard lock
    assign data_ok = latch_reg
                   & ~seph_pkg::in_prot(bpf_reg, addr_reg);
    // Next-state logic of the serial engine
    always_comb begin
        phase_next = phase_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        out_next = out_reg;
        ocnt_next = ocnt_reg;
        stat_d_next = stat_d_reg;
        lock_next = lock_reg;
        bpf_next = bpf_reg;
        latch_next = latch_reg;
        spend_next = spend_reg;
        wpend_next = wpend_reg;
        arr_next = arr_reg;
        sdo_next = sdo_reg;
        busy_cnt_next = busy ? busy_cnt_reg - 8'h01 : busy_cnt_reg;
        armed_next = armed_reg | sel_fall;
        // Pause only starts while selected with clock low
        paused_next = hold_low
                    & (paused_reg | (selected & ~sclk_s));
        if (active && sclk_rise) begin
            sh_next = {sh_reg[14:0], din};
            cnt_next = cnt_reg + 4'h1;
            case (phase_reg)
                seph_pkg::PH_CMD: if (byte_end) begin
                    cnt_next = 4'h0;
                    phase_next = seph_pkg::PH_IDLE;
                    if (rx_byte == seph_pkg::CMD_STAT_RD) begin
                        phase_next = seph_pkg::PH_STAT_OUT;
                        out_next = status_reg;
                        ocnt_next = 3'h0;
                    end else if (!busy) begin
                        case (rx_byte)
                            seph_pkg::CMD_LATCH_SET: latch_next = 1'b1;
                            seph_pkg::CMD_LATCH_CLR: latch_next = 1'b0;
                            seph_pkg::CMD_STAT_WR:
                                phase_next = seph_pkg::PH_STAT_DATA;
                            seph_pkg::CMD_ARR_WR:
                                phase_next = seph_pkg::PH_ADDR;
                            default: phase_next = seph_pkg::PH_IDLE;
                        endcase
                    end
                end
                seph_pkg::PH_STAT_DATA: if (byte_end) begin
                    stat_d_next = rx_byte;
                    spend_next = 1'b1;
                    phase_next = seph_pkg::PH_IDLE;
                end
                seph_pkg::PH_ADDR: if (cnt_reg == seph_pkg::ADDR_LAST) begin
                    addr_next = sh_next;
                    cnt_next = 4'h0;
                    phase_next = seph_pkg::PH_DATA;
                end
                seph_pkg::PH_DATA: if (byte_end) begin
                    cnt_next = 4'h0;
                    arr_next = {1'b1, data_ok, addr_reg, rx_byte};
                    wpend_next = wpend_reg | data_ok;
                    addr_next = addr_reg + 16'h0001;
                end
                // A clock beyond the status byte cancels the status write
                seph_pkg::PH_IDLE: spend_next = 1'b0;
                default: ;
            endcase
        end
        // Status streams repeatedly, reloaded every eight bits
        if (active && sclk_fall
            && phase_reg == seph_pkg::PH_STAT_OUT) begin
            sdo_next = out_reg[7];
            ocnt_next = ocnt_reg + 3'h1;
            out_next = (ocnt_reg == 3'h7) ? status_reg
                                          : {out_reg[6:0], 1'b0};
        end
        // Deselect ends the sequence and commits pending writes
        if (sel_rise) begin
            phase_next = seph_pkg::PH_CMD;
            cnt_next = 4'h0;
            spend_next = 1'b0;
            wpend_next = 1'b0;
            if (spend_reg) begin
                latch_next = 1'b0;
                if (latch_reg && !hard_lock_state) begin
                    lock_next = stat_d_reg[seph_pkg::ST_LOCK];
                    bpf_next = stat_d_reg[seph_pkg::ST_BP_HI:
                                          seph_pkg::ST_BP_LO];
                    busy_cnt_next = 8'(seph_pkg::BUSY_CYC);
                end
            end
            if (wpend_reg) begin
                latch_next = 1'b0;
                busy_cnt_next = 8'(seph_pkg::BUSY_CYC);
            end
        end
        // Output driven only while selected, unpaused and streaming
        oe_next = selected & ~paused_next & armed_reg
                & (phase_reg == seph_pkg::PH_STAT_OUT);
    end

    // Registers of the serial engine
    always_ff @(posedge core_clk) begin
        if (srst) begin
            phase_reg <= seph_pkg::PH_CMD;
            sh_reg <= 16'h0000;
            cnt_reg <= 4'h0;
            addr_reg <= 16'h0000;
            out_reg <= 8'h00;
            ocnt_reg <= 3'h0;
            stat_d_reg <= 8'h00;
            lock_reg <= NV_INIT[seph_pkg::ST_LOCK];
            bpf_reg <= NV_INIT[seph_pkg::ST_BP_HI:seph_pkg::ST_BP_LO];
            latch_reg <= 1'b0;
            spend_reg <= 1'b0;
            wpend_reg <= 1'b0;
            arr_reg <= 26'h0000000;
            sdo_reg <= 1'b0;
            oe_reg <= 1'b0;
            busy_cnt_reg <= 8'h00;
            armed_reg <= 1'b0;
            paused_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            out_reg <= out_next;
            ocnt_reg <= ocnt_next;
            stat_d_reg <= stat_d_next;
            lock_reg <= lock_next;
            bpf_reg <= bpf_next;
            latch_reg <= latch_next;
            spend_reg <= spend_next;
            wpend_reg <= wpend_next;
            arr_reg <= arr_next;
            sdo_reg <= sdo_next;
            oe_reg <= oe_next;
            busy_cnt_reg <= busy_cnt_next;
            armed_reg <= armed_next;
            paused_reg <= paused_next;
        end
    end
    assign sdo = sdo_reg;
    assign sdo_oe = oe_reg;
    ////////////////////////////////////////////////////////////////////
    // Wishbone slave, one wait state, unmapped reads give zero
    logic        ack_next, en_next, wb_req;
    logic [31:0] dat_next;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always_comb begin
        ack_next = wb_req;
        en_next = en_reg;
        dat_next = 32'h00000000;
        if (wb_req) begin
            case (wb_adr_i)
                seph_pkg::ADR_STATUS:
                    dat_next = {18'h00000, ~selected & ~busy, selected,
                                paused_reg, armed_reg, ~hard_lock_state,
                                hard_lock_state, status_reg};
                seph_pkg::ADR_CTRL: begin
                    dat_next = {31'h00000000, en_reg};
                    if (wb_we_i && wb_sel_i[0])
                        en_next = wb_dat_i[0];
                end
                seph_pkg::ADR_ARRWR: dat_next = {6'h00, arr_reg};
                default: dat_next = 32'h00000000;
            endcase
        end
    end
    // Bus registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            en_reg <= seph_pkg::CTRL_RST;
        end else begin
            wb_ack_o <= ack_next;
            wb_dat_o <= dat_next;
            en_reg <= en_next;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_commit;
        sel_rise && spend_reg;
    endsequence
    property p_desel_off;
        !selected |=> !sdo_oe;
    endproperty
    a_desel_off: assert property (p_desel_off)
        else $error("output enabled while deselected");
    property p_unarmed;
        !armed_reg |=> !sdo_oe && !latch_reg;
    endproperty
    a_unarmed: assert property (p_unarmed)
        else $error("activity before first select");
    property p_stat_ok;
        s_commit and latch_reg && !hard_lock_state
            |=> lock_reg == $past(stat_d_reg[7]) && !latch_reg && busy;
    endproperty
    a_stat_ok: assert property (p_stat_ok)
        else $error("permitted status write lost");
    property p_hard;
        s_commit and hard_lock_state |=> $stable(lock_reg)
            && $stable(bpf_reg) && !latch_reg;
    endproperty
    a_hard: assert property (p_hard)
        else $error("status changed under hard lock");
    property p_blk;
        active && sclk_rise && phase_reg == seph_pkg::PH_DATA && byte_end
            |=> arr_reg[24] == ($past(latch_reg)
              && !seph_pkg::in_prot($past(bpf_reg), $past(addr_reg)));
    endproperty
    a_blk: assert property (p_blk)
        else $error("array write gating wrong");
    property p_pause_in;
        selected && hold_low && !sclk_s |=> paused_reg ##1 !sdo_oe;
    endproperty
    a_pause_in: assert property (p_pause_in)
        else $error("pause not entered");
    property p_pause_hold;
        paused_reg && sel_rise == 1'b0 |=> $stable(sh_reg) && $stable(cnt_reg);
    endproperty
    a_pause_hold: assert property (p_pause_hold)
        else $error("sequence changed while paused");
    property p_pause_stay;
        paused_reg && hold_low |=> paused_reg;
    endproperty
    a_pause_stay: assert property (p_pause_stay)
        else $error("pause left while input low");
    property p_latch_set;
        active && sclk_rise && phase_reg == seph_pkg::PH_CMD && byte_end
            && !busy && rx_byte == seph_pkg::CMD_LATCH_SET |=> latch_reg;
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("latch not set");
endmodule // seph_core
`default_nettype wire

// [verification/seph_spi_master.sv]
`timescale 1ns/1ps
`default_nettype none
module seph_spi_master (
    // Serial pins towards the device
    output logic      sclk,
    output logic      unit_en_n,
    output logic      sdi,
    output logic      pause_n,
    // Resolved data-out wire
    input  wire logic sdo_w
);
    localparam int HALF_NS = 160;
    // Mode 0 master: clock idles low and stands still between frames
    initial begin
        sclk = 1'b0;
        unit_en_n = 1'b1;
        sdi = 1'b0;
        pause_n = 1'b1;
    end
    // Odd lead-in keeps frames off the core clock phase
    task automatic sel();
        #37;
        unit_en_n = 1'b0;
        #HALF_NS;
    endtask
    // MSB first; sdi only moves while sclk is low
    task automatic bits(input logic [31:0] d, input int n,
                        output logic [31:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = d[i];
            #HALF_NS;
            sclk = 1'b1;
            #(HALF_NS - 10);
            // Sampled late: sdo trails the fall by the sync delay
            r = {r[30:0], sdo_w};
            #10;
            sclk = 1'b0;
        end
    endtask
    // Idle data line shows the inverse so stale bits never look valid
    task automatic desel();
        #HALF_NS;
        unit_en_n = 1'b1;
        sdi = ~sdi;
        #200;
    endtask
    // Only ever called with sclk low
    task automatic pause(input logic v);
        pause_n = v;
        #200;
    endtask
endmodule // seph_spi_master
`default_nettype wire

// [verification/seph_core_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module seph_core_tb_top;
    typedef struct {
        logic [31:0] exp;
        logic [31:0] msk;
    } seph_note_s;
    logic        core_clk;
    logic        srst;
    logic        wb_cyc, wb_stb, wb_we, wb_ack_o, protect_n;
    logic [3:0]  wb_adr, wb_sel;
    logic        wb_lane0 = 1'b1;
    logic [31:0] wb_dat, wb_dat_o, r;
    wire         sclk, unit_en_n, sdi, pause_n, sdo, sdo_oe, sdo_w;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    seph_note_s  notes[$];
    seph_note_s  nt;

    // Released line shows the inverse, so a missing enable spoils the data
    assign sdo_w = sdo_oe ? sdo : ~sdo;

    seph_core #(.NV_INIT(8'h00)) seph_core_i (
        .core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sclk(sclk), .unit_en_n(unit_en_n),
        .sdi(sdi), .pause_n(pause_n), .protect_n(protect_n),
        .sdo(sdo), .sdo_oe(sdo_oe));
    seph_spi_master seph_spi_master_i (
        .sclk(sclk), .unit_en_n(unit_en_n), .sdi(sdi),
        .pause_n(pause_n), .sdo_w(sdo_w));

    ////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Oldest note is matched against each read answer
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && wb_we === 1'b0 && notes.size() > 0) begin
            nt = notes.pop_front();
            check("wb_dat_o", nt.exp, wb_dat_o & nt.msk);
        end
    end
    // Classic cycle; for reads d carries the expected word
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d, input logic [31:0] m);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= {3'($urandom), wb_lane0};
        wb_dat <= d;
        if (!we) notes.push_back('{d & m, m});
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            check("wb_ack_o", 32'h1, 32'h0);
            stop_test();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic st(input logic [31:0] e, input logic [31:0] m);
        wb(1'b0, seph_pkg::ADR_STATUS, e, m);
    endtask
    task automatic spi(input logic [31:0] d, input int n);
        seph_spi_master_i.sel();
        seph_spi_master_i.bits(d, n, r);
        seph_spi_master_i.desel();
    endtask
    task automatic cmd(input logic [7:0] c);
        spi({24'h0, c}, 8);
    endtask
    // Pin goes through the sync stages before it counts
    task automatic pin(input logic v);
        @(posedge core_clk);
        protect_n <= v;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic st_wr(input logic [7:0] v);
        cmd(seph_pkg::CMD_LATCH_SET);
        spi({16'h0, seph_pkg::CMD_STAT_WR, v}, 16);
        repeat (140) @(posedge core_clk);
    endtask
    task automatic arr_wr(input logic [15:0] a, input logic acc);
        logic [7:0] b;
        b = 8'($urandom);
        cmd(seph_pkg::CMD_LATCH_SET);
        spi({seph_pkg::CMD_ARR_WR, a, b}, 32);
        repeat (140) @(posedge core_clk);
        wb(1'b0, seph_pkg::ADR_ARRWR, {6'h00, 1'b1, acc, a, b},
           32'h03FF_FFFF);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
        protect_n = 1'b1;
        srst = 1'b1;
        void'($urandom(32'hF5E41362));
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        st(32'h0000_2200, 32'h0000_3FFF);
        wb(1'b0, seph_pkg::ADR_CTRL, 32'h1, 32'h1);
        wb(1'b1, 4'hC, 32'hFFFF_FFFF, '1);
        wb(1'b0, 4'hC, 32'h0, '1);
        cmd(seph_pkg::CMD_LATCH_SET);
        st(32'h602, 32'hFFF);
        cmd(seph_pkg::CMD_LATCH_CLR);
        st(32'h600, 32'hFFF);
        // Link disabled: a latch-set must be ignored
        wb(1'b1, seph_pkg::ADR_CTRL, 32'h0, '1);
        cmd(seph_pkg::CMD_LATCH_SET);
        st(32'h0, 32'h2);
        wb(1'b1, seph_pkg::ADR_CTRL, 32'h1, '1);
        // Lane 0 off: the enable write must be dropped
        wb_lane0 = 1'b0;
        wb(1'b1, seph_pkg::ADR_CTRL, 32'h0, '1);
        wb_lane0 = 1'b1;
        wb(1'b0, seph_pkg::ADR_CTRL, 32'h1, 32'h1);
        spi({16'h0, seph_pkg::CMD_STAT_WR, 8'h8C}, 16);
        repeat (140) @(posedge core_clk);
        st(32'h200, 32'h3FF);
        pin(1'b0);
        cmd(seph_pkg::CMD_LATCH_SET);
        spi({16'h0, seph_pkg::CMD_STAT_WR, 8'h84}, 16);
        st(32'h1, 32'h1);
        repeat (140) @(posedge core_clk);
        st(32'h184, 32'h3FF);
        st_wr(8'h00);
        st(32'h184, 32'h3FF);
        arr_wr(16'h7000, 1'b0);
        arr_wr(16'h1000, 1'b1);
        pin(1'b1);
        st(32'h284, 32'h3FD);
        arr_wr(16'h7000, 1'b0);
        st_wr(8'h00);
        st(32'h200, 32'h3FF);
        pin(1'b0);
        st_wr(8'h08);
        st(32'h208, 32'h3FF);
        pin(1'b1);
        st_wr(8'h88);
        pin(1'b0);
        st(32'h188, 32'h3FF);
        spi({16'h0, seph_pkg::CMD_STAT_RD, 8'h00}, 16);
        check("sdo", 32'h88, r & 32'hFF);
        check("sdo_oe", 32'h0, {31'h0, sdo_oe});
        // Pause mid-command with clock noise while paused
        seph_spi_master_i.sel();
        seph_spi_master_i.bits(32'h0, 4, r);
        seph_spi_master_i.pause(1'b0);
        st(32'h800, 32'h800);
        check("sdo_oe", 32'h0, {31'h0, sdo_oe});
        seph_spi_master_i.bits(32'hF, 4, r);
        seph_spi_master_i.pause(1'b1);
        seph_spi_master_i.bits(32'h6, 4, r);
        seph_spi_master_i.desel();
        st(32'h2, 32'h2);
        // Deselect while paused drops the half command
        cmd(seph_pkg::CMD_LATCH_CLR);
        seph_spi_master_i.sel();
        seph_spi_master_i.bits(32'h0, 4, r);
        seph_spi_master_i.pause(1'b0);
        seph_spi_master_i.desel();
        st(32'h800, 32'h1800);
        seph_spi_master_i.pause(1'b1);
        cmd(seph_pkg::CMD_LATCH_SET);
        st(32'h2, 32'h2);
        seph_spi_master_i.pause(1'b0);
        st(32'h0, 32'h800);
        seph_spi_master_i.pause(1'b1);
        stop_test();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #(60000 * 40);
        n_mismatch++;
        stop_test();
    end
endmodule // seph_core_tb_top
`default_nettype wire
